/* File: tsdt_top.sv */
`timescale 1ns/10ps
module tsdt_top #(
  parameter bit SECOND_INST = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] timer_global_control,
  input wire logic [5:0] high_res_prescale,
  input wire logic [7:0] loop_res_prescale,
  input wire logic sync_in,
  output logic sync_out,
  output logic loop_tick,
  output logic slave_locked,
  input wire logic [31:0] timer_out,
  input wire logic [31:0] timer_oe_req,
  input wire logic tap_internal_only,
  input wire logic [31:0] output_disable_select,
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  output logic [31:0] pin_out,
  output logic [31:0] pin_oe,
  output logic freq_compare_clk,
  input wire logic monitor_enable,
  input wire logic [31:0] peer_out,
  output logic [31:0] monitor_out,
  input wire logic [7:0] transfer_request_line,
  input wire logic [7:0] request_condition,
  input wire logic cfg_we,
  input wire logic [2:0] cfg_idx,
  input wire tsdt_pkg::tsdt_cfg_t cfg_wdata,
  output logic [11:0] timer_rd_addr,
  input wire logic [63:0] timer_rd_data,
  input wire logic [31:0] mpu_base,
  input wire logic [31:0] mpu_limit,
  input wire logic mpu_enable,
  input wire logic mpu_fault_clr,
  output logic mpu_fault,
  output logic parity_error,
  input wire logic [7:0] lost_clr,
  output logic [7:0] request_lost,
  output logic mem_valid,
  input wire logic mem_ready,
  output tsdt_pkg::tsdt_xfer_t mem_word
);

  // Whole state of the block in one record.
  typedef struct packed {
    logic [5:0] hr_cnt;
    logic [7:0] lr_cnt;
    logic locked;
    logic sync_out;
    logic loop_tick;
    logic sync_prev;
    logic pd_meta;
    logic pd_sync;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic tap;
    logic [31:0] mon;
    tsdt_pkg::tsdt_cfg_t [7:0] cfg;
    logic [7:0] par;
    tsdt_pkg::tsdt_dyn_t [7:0] dyn;
    logic [7:0] pending;
    logic [7:0] lost;
    tsdt_pkg::tsdt_eng_t eng;
    logic [2:0] cur;
    logic [11:0] rd_addr;
    tsdt_pkg::tsdt_xfer_t q0;
    tsdt_pkg::tsdt_xfer_t q1;
    logic [1:0] cnt;
    logic out_valid;
    logic mpu_fault;
    logic par_err;
  } tsdt_state_t;

  tsdt_state_t q;
  tsdt_state_t d;

  // Static selections that differ between the two instances.
  localparam int TAP_CH = SECOND_INST ? tsdt_pkg::TAP_CH_SECOND : tsdt_pkg::TAP_CH_FIRST;
  localparam int PD_BIT = SECOND_INST ? tsdt_pkg::PDIS_BIT_SECOND : tsdt_pkg::PDIS_BIT_FIRST;

  // Combinational next state.
  always_comb
  begin
    logic is_master;
    logic hr_wrap;
    logic lr_wrap;
    logic sync_edge;
    logic pd_raw;
    logic [7:0] req;
    logic found;
    logic [2:0] pick;
    logic [31:0] mstep;
    logic [11:0] tstep;
    logic pop;
    logic push;
    logic viol;
    tsdt_pkg::tsdt_cfg_t c;
    tsdt_pkg::tsdt_dyn_t y;
    tsdt_pkg::tsdt_xfer_t w;
    logic [31:0] tap_mask;
    d = q;
    is_master = timer_global_control[tsdt_pkg::MASTER_BIT];
    hr_wrap = 1'b0;
    lr_wrap = 1'b0;
    sync_edge = 1'b0;
    pd_raw = SECOND_INST ? port_b_pin[PD_BIT] : port_a_pin[PD_BIT];
    req = 8'h00;
    found = 1'b0;
    pick = 3'h0;
    mstep = 32'h0000_0000;
    tstep = 12'h000;
    pop = 1'b0;
    push = 1'b0;
    viol = 1'b0;
    c = q.cfg[q.cur];
    y = q.dyn[q.cur];
    w = q.q0;
    tap_mask = 32'h0000_0000;

    // Prescaler: high-res divider feeding the loop divider.
    sync_edge = sync_in & ~q.sync_prev;
    d.sync_prev = sync_in;
    d.loop_tick = 1'b0;
    d.sync_out = 1'b0;
    if (!is_master && sync_edge)
    begin
      d.hr_cnt = tsdt_pkg::HR_RESET;
      d.lr_cnt = tsdt_pkg::LR_RESET;
      d.locked = 1'b1;
    end
    else if (is_master || q.locked)
    begin
      hr_wrap = (q.hr_cnt >= high_res_prescale);
      lr_wrap = hr_wrap && (q.lr_cnt >= loop_res_prescale);
      d.hr_cnt = hr_wrap ? tsdt_pkg::HR_RESET : q.hr_cnt + 6'h01;
      if (hr_wrap)
      begin
        d.lr_cnt = lr_wrap ? tsdt_pkg::LR_RESET : q.lr_cnt + 8'h01;
      end
      d.loop_tick = lr_wrap;
      d.sync_out = is_master && lr_wrap;
    end
    if (is_master)
    begin
      d.locked = 1'b0;
    end

    // Pin-disable input passes two flops before use.
    d.pd_meta = pd_raw;
    d.pd_sync = q.pd_meta;

    // Pad drive with fault disable and internal-only tap channel.
    tap_mask[TAP_CH] = tap_internal_only;
    d.pin_out = timer_out;
    d.pin_oe = timer_oe_req & ~tap_mask;
    if (!q.pd_sync)
    begin
      d.pin_oe = d.pin_oe & ~output_disable_select;
    end
    d.tap = timer_out[TAP_CH];
    d.mon = monitor_enable ? peer_out : 32'h0000_0000;

    // Packet configuration writes, stored with an even-parity bit.
    if (cfg_we)
    begin
      d.cfg[cfg_idx] = cfg_wdata;
      d.par[cfg_idx] = ^cfg_wdata;
      d.dyn[cfg_idx] = '0;
    end

    // Gated requests; a repeat while still pending is lost, set beats clear.
    req = transfer_request_line & request_condition;
    d.lost = (q.lost & ~lost_clr) | (req & q.pending);
    d.pending = q.pending | req;

    // Output buffer pop side.
    pop = q.out_valid && mem_ready;

    // Transfer engine.
    unique case (q.eng)
      tsdt_pkg::ENG_IDLE:
      begin
        for (int i = tsdt_pkg::NUM_PKT - 1; i >= 0; i--)
        begin
          if (q.pending[i])
          begin
            found = 1'b1;
            pick = 3'(i);
          end
        end
        if (found)
        begin
          d.pending[pick] = req[pick];
          c = q.cfg[pick];
          y = q.dyn[pick];
          d.cur = pick;
          if (^c != q.par[pick])
          begin
            d.par_err = 1'b1;
          end
          else if (c.enable && !y.done)
          begin
            if (!y.active)
            begin
              y.mem_addr = c.mem_base_a;
              y.timer_addr = c.timer_addr;
              y.remain = c.count;
              y.buf_b = 1'b0;
              y.active = 1'b1;
            end
            d.dyn[pick] = y;
            d.rd_addr = y.timer_addr;
            d.eng = tsdt_pkg::ENG_FETCH;
          end
        end
      end
      tsdt_pkg::ENG_FETCH:
      begin
        d.eng = tsdt_pkg::ENG_PUSH;
      end
      tsdt_pkg::ENG_PUSH:
      begin
        w.mem_addr = y.mem_addr;
        w.wide64 = c.wide64;
        w.data = c.wide64 ? timer_rd_data : {32'h0000_0000, timer_rd_data[31:0]};
        w.pkt = q.cur;
        viol = mpu_enable && ((y.mem_addr < mpu_base) || (y.mem_addr > mpu_limit));
        if (viol)
        begin
          d.mpu_fault = 1'b1;
          d.dyn[q.cur].active = 1'b0;
          d.eng = tsdt_pkg::ENG_IDLE;
        end
        else if (q.cnt != 2'd2 || pop)
        begin
          push = 1'b1;
          unique case (c.minc)
            tsdt_pkg::MEM_INC32: mstep = tsdt_pkg::MSTEP_32;
            tsdt_pkg::MEM_INC64: mstep = tsdt_pkg::MSTEP_64;
            default: mstep = 32'h0000_0000;
          endcase
          tstep = c.tstep16 ? tsdt_pkg::TSTEP_LARGE : tsdt_pkg::TSTEP_SMALL;
          y.mem_addr = y.mem_addr + mstep;
          y.timer_addr = y.timer_addr + tstep;
          y.remain = y.remain - 8'h01;
          if (y.remain == 8'h00)
          begin
            unique case (c.mode)
              tsdt_pkg::MODE_CIRCULAR:
              begin
                y.mem_addr = y.buf_b ? c.mem_base_b : c.mem_base_a;
              end
              tsdt_pkg::MODE_AUTO_SWITCH:
              begin
                y.buf_b = ~y.buf_b;
                y.mem_addr = y.buf_b ? c.mem_base_b : c.mem_base_a;
              end
              default:
              begin
                y.active = 1'b0;
                y.done = 1'b1;
              end
            endcase
            y.timer_addr = c.timer_addr;
            y.remain = c.count;
          end
          d.dyn[q.cur] = y;
          d.eng = tsdt_pkg::ENG_IDLE;
        end
      end
      default:
      begin
        d.eng = tsdt_pkg::ENG_IDLE;
      end
    endcase

    // Two-entry buffer: q0 is the head shown on the memory port.
    if (pop)
    begin
      d.q0 = q.q1;
    end
    if (push)
    begin
      if (q.cnt == 2'd0 || (q.cnt == 2'd1 && pop))
      begin
        d.q0 = w;
      end
      else
      begin
        d.q1 = w;
      end
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
    d.out_valid = (d.cnt != 2'd0);

    // Sticky fault, set beats clear.
    if (mpu_fault_clr && !(viol && q.eng == tsdt_pkg::ENG_PUSH))
    begin
      d.mpu_fault = 1'b0;
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q <= '0;
      q.pd_meta <= 1'b1;
      q.pd_sync <= 1'b1;
      q.eng <= tsdt_pkg::ENG_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign sync_out = q.sync_out;
  assign loop_tick = q.loop_tick;
  assign slave_locked = q.locked;
  assign pin_out = q.pin_out;
  assign pin_oe = q.pin_oe;
  assign freq_compare_clk = q.tap;
  assign monitor_out = q.mon;
  assign timer_rd_addr = q.rd_addr;
  assign mpu_fault = q.mpu_fault;
  assign parity_error = q.par_err;
  assign request_lost = q.lost;
  assign mem_valid = q.out_valid;
  assign mem_word = q.q0;

endmodule : tsdt_top

/* File: tsdt_pkg.sv */
package tsdt_pkg;

  // Packet count and request width.
  localparam int NUM_PKT = 8;
  localparam int PKT_W = 3;
  localparam int CH_W = 32;

  // Role bit inside the global control word; zero after reset means slave.
  localparam int MASTER_BIT = 16;
  localparam logic [31:0] GCTL_RESET = 32'h0000_0000;

  // Comparator tap channel and pin-disable port bit for each instance.
  localparam int TAP_CH_FIRST = 31;
  localparam int TAP_CH_SECOND = 0;
  localparam int PDIS_BIT_FIRST = 5;
  localparam int PDIS_BIT_SECOND = 2;

  // Address steps of the transfer unit in bytes.
  localparam logic [11:0] TSTEP_SMALL = 12'h008;
  localparam logic [11:0] TSTEP_LARGE = 12'h010;
  localparam logic [31:0] MSTEP_32 = 32'h0000_0004;
  localparam logic [31:0] MSTEP_64 = 32'h0000_0008;

  // Reset values.
  localparam logic [5:0] HR_RESET = 6'h00;
  localparam logic [7:0] LR_RESET = 8'h00;

  typedef enum logic [1:0] {MODE_ONE_SHOT, MODE_CIRCULAR, MODE_AUTO_SWITCH} tsdt_mode_t;
  typedef enum logic [1:0] {MEM_FIXED, MEM_INC32, MEM_INC64} tsdt_minc_t;
  typedef enum logic [1:0] {ENG_IDLE, ENG_FETCH, ENG_PUSH} tsdt_eng_t;

  // Static contents of one control packet.
  typedef struct packed {
    logic [31:0] mem_base_a;
    logic [31:0] mem_base_b;
    logic [11:0] timer_addr;
    logic [7:0] count;
    tsdt_mode_t mode;
    tsdt_minc_t minc;
    logic wide64;
    logic tstep16;
    logic enable;
  } tsdt_cfg_t;

  // Running position of one control packet.
  typedef struct packed {
    logic [31:0] mem_addr;
    logic [11:0] timer_addr;
    logic [7:0] remain;
    logic buf_b;
    logic active;
    logic done;
  } tsdt_dyn_t;

  // One word toward system memory.
  typedef struct packed {
    logic [31:0] mem_addr;
    logic [63:0] data;
    logic wide64;
    logic [2:0] pkt;
  } tsdt_xfer_t;

endpackage : tsdt_pkg

/* File: tsdt_mem_model.sv */
`timescale 1ns/10ps
// Stands in for system memory and the timer RAM read port of one instance.
module tsdt_mem_model (
  input wire logic clk,
  input wire logic stall,
  input wire logic mem_valid,
  input wire tsdt_pkg::tsdt_xfer_t mem_word,
  output logic mem_ready,
  input wire logic [11:0] timer_rd_addr,
  output logic [63:0] timer_rd_data
);
  tsdt_pkg::tsdt_xfer_t log_q[$];
  // Timer RAM returns its address low and ones high, so a narrow word must drop the top half.
  assign timer_rd_data = {32'hffff_ffff, 20'h00000, timer_rd_addr};
  // Memory accepts at once unless the bench holds it off to fill the buffer.
  assign mem_ready = !stall;
  // Every accepted word is logged in order for the bench to judge.
  always @(posedge clk)
  begin
    if (mem_valid && mem_ready)
    begin
      log_q.push_back(mem_word);
    end
  end
endmodule : tsdt_mem_model

/* File: tsdt_assertions.sv */
`timescale 1ns/10ps
// Watches the top module's ports of the first instance.
module tsdt_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] timer_global_control,
  input wire logic sync_in,
  input wire logic sync_out,
  input wire logic loop_tick,
  input wire logic slave_locked,
  input wire logic [31:0] timer_out,
  input wire logic [31:0] timer_oe_req,
  input wire logic tap_internal_only,
  input wire logic [31:0] output_disable_select,
  input wire logic [7:0] port_a_pin,
  input wire logic [31:0] pin_oe,
  input wire logic freq_compare_clk,
  input wire logic monitor_enable,
  input wire logic [31:0] peer_out,
  input wire logic [31:0] monitor_out,
  input wire logic mem_valid,
  input wire logic mem_ready,
  input wire tsdt_pkg::tsdt_xfer_t mem_word
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // A settled slave never drives the sync pulse.
  property p_slave_quiet;
    !timer_global_control[16] && !$past(timer_global_control[16]) |-> !sync_out;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("sync pulse from slave");
  // A settled master sends its sync pulse together with every loop wrap.
  property p_master_sync;
    timer_global_control[16] && $past(timer_global_control[16]) |-> sync_out == loop_tick;
  endproperty
  a_master_sync: assert property (p_master_sync) else $error("sync not at loop wrap");
  // A rising sync input locks a slave within one cycle.
  property p_lock;
    !timer_global_control[16] && !$past(timer_global_control[16]) && $rose(sync_in)
      |-> ##[0:1] slave_locked;
  endproperty
  a_lock: assert property (p_lock) else $error("slave did not lock");
  // An unlocked slave keeps its loop counter still.
  property p_unlocked_quiet;
    !timer_global_control[16] && !$past(timer_global_control[16]) && !slave_locked |-> !loop_tick;
  endproperty
  a_unlocked_quiet: assert property (p_unlocked_quiet) else $error("tick before lock");
  // Four cycles of pin disable low tri-state every selected output.
  property p_pin_off;
    !port_a_pin[5] [*4] |-> (pin_oe & $past(output_disable_select)) == 32'h0000_0000;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("selected output still driven");
  // With pin disable high the pads follow the requests, minus an internal-only tap.
  property p_pin_on;
    port_a_pin[5] [*4] |-> pin_oe == ($past(timer_oe_req) & {~$past(tap_internal_only), 31'h7fff_ffff});
  endproperty
  a_pin_on: assert property (p_pin_on) else $error("pad enable wrong");
  // The comparator clock copies channel 31 one cycle late.
  property p_tap;
    !$past(rst) |-> freq_compare_clk == $past(timer_out[31]);
  endproperty
  a_tap: assert property (p_tap) else $error("comparator tap wrong");
  // The peer's outputs are seen only while monitoring is on.
  property p_mon;
    !$past(rst) |-> monitor_out == ($past(monitor_enable) ? $past(peer_out) : 32'h0000_0000);
  endproperty
  a_mon: assert property (p_mon) else $error("monitor output wrong");
  // A stalled word stays offered unchanged.
  property p_hold;
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_word);
  endproperty
  a_hold: assert property (p_hold) else $error("stalled word changed");
  // A narrow transfer leaves the upper half zero.
  property p_narrow;
    mem_valid && !mem_word.wide64 |-> mem_word.data[63:32] == 32'h0000_0000;
  endproperty
  a_narrow: assert property (p_narrow) else $error("narrow word has upper data");
endmodule : tsdt_chk

bind tsdt_top tsdt_chk i_chk (.clk, .rst, .timer_global_control, .sync_in, .sync_out,
  .loop_tick, .slave_locked, .timer_out, .timer_oe_req, .tap_internal_only,
  .output_disable_select, .port_a_pin, .pin_oe, .freq_compare_clk, .monitor_enable,
  .peer_out, .monitor_out, .mem_valid, .mem_ready, .mem_word);

/* File: timer_sync_disable_transfer_bench.sv */
`timescale 1ns/10ps
module timer_sync_disable_transfer_bench;
  logic clk = 1'b0, rst = 1'b1, sync_in = 1'b0, tap_internal_only = 1'b0, monitor_enable = 1'b0;
  logic cfg_we = 1'b0, mpu_enable = 1'b0, mpu_fault_clr = 1'b0, stall = 1'b0;
  logic [2:0] cfg_idx = 3'h0;
  logic [5:0] high_res_prescale = 6'h01;
  logic [7:0] loop_res_prescale = 8'h02, port_a_pin = 8'hff, port_b_pin = 8'hff;
  logic [7:0] transfer_request_line = 8'h00, request_condition = 8'h00, lost_clr = 8'h00;
  logic [31:0] timer_global_control = 32'h0, timer_out = 32'h0, timer_oe_req = 32'h0;
  logic [31:0] output_disable_select = 32'h0, peer_out = 32'h0, mpu_base = 32'h0;
  logic [31:0] mpu_limit = 32'h0, pin_out, pin_oe, monitor_out;
  tsdt_pkg::tsdt_cfg_t cfg_wdata = '0;
  tsdt_pkg::tsdt_xfer_t mem_word;
  logic [63:0] timer_rd_data;
  logic mem_ready, sync_out, loop_tick, slave_locked, freq_compare_clk, mpu_fault;
  logic parity_error, mem_valid;
  logic [11:0] timer_rd_addr;
  logic [7:0] request_lost;
  int error_cnt = 0, comparisons = 0;

  tsdt_mem_model i_mem (.clk, .stall, .mem_valid, .mem_word, .mem_ready, .timer_rd_addr,
    .timer_rd_data);
  tsdt_top i_dut (.clk, .rst, .timer_global_control, .high_res_prescale, .loop_res_prescale,
    .sync_in, .sync_out, .loop_tick, .slave_locked, .timer_out, .timer_oe_req,
    .tap_internal_only, .output_disable_select, .port_a_pin, .port_b_pin, .pin_out, .pin_oe,
    .freq_compare_clk, .monitor_enable, .peer_out, .monitor_out, .transfer_request_line,
    .request_condition, .cfg_we, .cfg_idx, .cfg_wdata, .timer_rd_addr, .timer_rd_data,
    .mpu_base, .mpu_limit, .mpu_enable, .mpu_fault_clr, .mpu_fault, .parity_error, .lost_clr,
    .request_lost, .mem_valid, .mem_ready, .mem_word);

  // Free-running 100 MHz clock.
  initial
  begin
    forever #5 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic count_ticks(input int n, output int lt, output int so);
    lt = 0;
    so = 0;
    repeat (n)
    begin
      @(negedge clk);
      lt += loop_tick;
      so += sync_out;
    end
  endtask : count_ticks

  task automatic gap(output int d);
    d = 0;
    while (loop_tick !== 1'b1 && d < 50)
    begin
      @(negedge clk);
      d++;
    end
  endtask : gap

  task automatic pulse_sync;
    sync_in = 1'b1;
    cyc(1);
    sync_in = 1'b0;
  endtask : pulse_sync

  task automatic t_sync;
    int lt, so, d1, d2;
    count_ticks(20, lt, so);
    chk(lt, 0);
    pulse_sync();
    gap(d1);
    chk(slave_locked, 1'b1);
    count_ticks(60, lt, so);
    chk(lt, 10);
    chk(so, 0);
    cyc(2);
    pulse_sync();
    gap(d2);
    chk(d2, d1);
  endtask : t_sync

  task automatic t_master;
    int lt, so;
    timer_global_control = 32'h0001_0000;
    high_res_prescale = 6'h00;
    loop_res_prescale = 8'h01;
    cyc(4);
    count_ticks(20, lt, so);
    chk(lt, 10);
    chk(so, 10);
    timer_global_control = 32'h0000_0000;
  endtask : t_master

  task automatic t_pins;
    timer_out = 32'h8000_a5c3; // Levels stand for many loop periods.
    timer_oe_req = 32'hffff_ffff;
    output_disable_select = 32'h0000_00f0;
    peer_out = 32'h1234_5678;
    monitor_enable = 1'b1;
    tap_internal_only = 1'b1;
    port_b_pin = 8'h00;
    cyc(4);
    chk(pin_out, 32'h8000_a5c3);
    chk(pin_oe, 32'h7fff_ffff);
    chk(freq_compare_clk, 1'b1);
    chk(monitor_out, 32'h1234_5678);
    port_a_pin = 8'hdf;
    monitor_enable = 1'b0;
    cyc(4);
    chk(pin_oe, 32'h7fff_ff0f);
    chk(monitor_out, 32'h0000_0000);
    port_a_pin = 8'hff;
  endtask : t_pins

  task automatic req(input logic [7:0] l, input logic [7:0] c);
    transfer_request_line = l;
    request_condition = c;
    cyc(1);
    transfer_request_line = 8'h00;
    cyc(6);
  endtask : req

  task automatic t_xfer;
    logic [31:0] ea [5] = '{32'h100, 32'h104, 32'h200, 32'h204, 32'h100};
    cfg_idx = 3'h2;
    cfg_wdata = '{32'h100, 32'h200, 12'h040, 8'h02, tsdt_pkg::MODE_AUTO_SWITCH,
      tsdt_pkg::MEM_INC32, 1'b0, 1'b1, 1'b1};
    cfg_we = 1'b1;
    cyc(1);
    cfg_we = 1'b0;
    req(8'h04, 8'hfb);
    chk(i_mem.log_q.size(), 0);
    stall = 1'b1;
    repeat (3) req(8'h04, 8'h04);
    chk(mem_valid, 1'b1);
    chk(i_mem.log_q.size(), 0);
    stall = 1'b0;
    cyc(6);
    repeat (2) req(8'h04, 8'h04);
    chk(i_mem.log_q.size(), 5);
    for (int k = 0; k < 5; k++)
    begin
      chk(i_mem.log_q[k].mem_addr, ea[k]);
      chk(i_mem.log_q[k].pkt, 3'h2);
    end
    chk(i_mem.log_q[0].data, 64'h0000_0000_0000_0040);
    chk(i_mem.log_q[1].data, 64'h0000_0000_0000_0050);
  endtask : t_xfer

  task automatic t_faults;
    transfer_request_line = 8'h01;
    request_condition = 8'h01;
    cyc(2);
    transfer_request_line = 8'h00;
    cyc(2);
    chk(request_lost, 8'h01);
    lost_clr = 8'h01;
    cyc(1);
    lost_clr = 8'h00;
    cyc(1);
    chk(request_lost, 8'h00);
    mpu_base = 32'h0000_1000;
    mpu_limit = 32'h0000_1fff;
    mpu_enable = 1'b1;
    req(8'h04, 8'h04);
    chk(mpu_fault, 1'b1);
    chk(i_mem.log_q.size(), 5);
    mpu_fault_clr = 1'b1;
    cyc(1);
    mpu_fault_clr = 1'b0;
    cyc(1);
    chk(mpu_fault, 1'b0);
    chk(parity_error, 1'b0);
  endtask : t_faults

  task automatic tally_and_finish;
    if (error_cnt == 0 && comparisons > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // Reset for five cycles, then run every scenario in turn.
  initial
  begin
    cyc(5);
    rst = 1'b0;
    t_sync();
    t_master();
    t_pins();
    t_xfer();
    t_faults();
    tally_and_finish();
  end

  // Cuts a hang short far beyond the expected run of under a thousand cycles.
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : timer_sync_disable_transfer_bench
